// [design/dma_channel_ring_repeat.sv]
// Contract
// - source address steps after every transfer
// - destination address steps after every transfer
// - offset mode adds the offset register
// - count falls by access size each transfer
// - longword access subtracts four
// - block size ignored in normal mode
// - block mode moves one programmed block
// - ring end reloads start, block continues
// - short final block moves remaining bytes
// - transfer end raises end interrupt
// - repeat area end raises its interrupt
//
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module dma_channel_ring_repeat (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // wishbone register slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // memory master
  output logic memReq,
  output logic memWe,
  output logic [31:0] memAddr,
  output logic [3:0] memSel,
  output logic [31:0] memWdata,
  input wire logic [31:0] memRdata,
  input wire logic memAck,
  // interrupt
  output logic irq
);
  import dma_ring_pkg::*;

  ////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    state_e state;        // sequencer
    logic [31:0] src;     // source_address
    logic [31:0] dst;     // destination_address
    logic [31:0] ofs;     // address_offset
    logic [31:0] cnt;     // remaining_byte_count
    logic [31:0] bsz;     // block_repeat_size
    logic [31:0] rStart;  // ring start
    logic [31:0] rSize;   // ring size in bytes
    logic en;             // transfer enable
    xfer_e xfer;          // transfer mode
    size_e size;          // access unit
    logic eStop;          // suspend on repeat end
    addr_mode_e srcMode;  // source update
    addr_mode_e dstMode;  // destination update
    logic ringEn;         // extended repeat on source
    logic [1:0] sts;      // sticky events
    logic [1:0] msk;      // interrupt mask
    logic [31:0] blkLeft; // bytes left in block
    logic [31:0] data;    // held transfer word
    logic [31:0] mAddr;   // memory address
    logic [3:0] mSel;     // memory lanes
    logic ack;            // bus answer
    logic [31:0] rdat;    // bus read data
  } state_s;
  state_s st;
  state_s next_st;
  ////////////////////////////////////////////////////////////////
  // address and size helpers
  logic [31:0] unitBytes;  // bytes per access
  logic [31:0] srcStep;    // stepped source
  logic [31:0] dstStep;    // stepped destination
  logic [31:0] ringEnd;    // first address past ring
  logic ringHit;           // source reached ring end
  logic xferDone;          // write half acknowledged
  logic [31:0] cntLeft;    // count after this transfer
  logic [31:0] blkAfter;   // block bytes after this transfer
  logic busHit;            // new bus request
  logic [31:0] wmask;      // byte-lane write mask
  logic [1:0] evtSet;      // events raised this cycle
  // access unit in bytes
  always_comb begin
    unique case (st.size)
      SZ_BYTE: unitBytes = 32'h00000001;
      SZ_WORD: unitBytes = 32'h00000002;
      default: unitBytes = 32'h00000004;
    endcase
  end
  // lane select for an address at the current unit
  function automatic logic [3:0] laneSel(input size_e sz, input logic [1:0] a);
    unique case (sz)
      SZ_BYTE: laneSel = 4'h1 << a;
      SZ_WORD: laneSel = a[1] ? 4'hc : 4'h3;
      default: laneSel = 4'hf;
    endcase
  endfunction : laneSel
  dma_addr_step #(.AW(32)) uSrcStep (
    .addr(st.src),
    .mode(st.srcMode),
    .unitBytes(unitBytes),
    .offset(st.ofs),
    .nextAddr(srcStep)
  );
  dma_addr_step #(.AW(32)) uDstStep (
    .addr(st.dst),
    .mode(st.dstMode),
    .unitBytes(unitBytes),
    .offset(st.ofs),
    .nextAddr(dstStep)
  );
  assign ringEnd = st.rStart + st.rSize;
  assign ringHit = st.ringEn && (srcStep == ringEnd);
  assign xferDone = (st.state == S_WRITE) && memAck;
  assign cntLeft = st.cnt - unitBytes;
  assign blkAfter = st.blkLeft - unitBytes;
  assign busHit = cyc_i && stb_i && !st.ack;
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  ////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_st = st;
    next_st.ack = busHit;
    evtSet = RST_IRQ;  // no event yet
    // register reads, answered with ack
    if (busHit) begin
      unique case (adr_i)
        OFS_SRC: next_st.rdat = st.src;
        OFS_DST: next_st.rdat = st.dst;
        OFS_OFFSET: next_st.rdat = st.ofs;
        OFS_COUNT: next_st.rdat = st.cnt;
        OFS_BSIZE: next_st.rdat = st.bsz;
        OFS_MODE: next_st.rdat = {26'h0, st.eStop, st.size, st.xfer, st.en};
        OFS_ADDRCTL: next_st.rdat = {27'h0, st.ringEn, st.dstMode, st.srcMode};
        OFS_RSTART: next_st.rdat = st.rStart;
        OFS_RSIZE: next_st.rdat = st.rSize;
        OFS_STATUS: next_st.rdat = {30'h0, st.sts};
        OFS_MASK: next_st.rdat = {30'h0, st.msk};
        default: next_st.rdat = RST_WORD;
      endcase
    end
    // sequencer
    unique case (st.state)
      S_IDLE: begin
        if (st.en && st.cnt != RST_WORD) begin
          if (st.blkLeft == RST_WORD) begin
            if (st.xfer == XF_NORMAL || st.bsz == RST_WORD) begin
              next_st.blkLeft = st.cnt;
            end else if (st.cnt < st.bsz) begin
              next_st.blkLeft = st.cnt;
            end else begin
              next_st.blkLeft = st.bsz;
            end
          end
          next_st.mAddr = st.src;
          next_st.mSel = laneSel(st.size, st.src[1:0]);
          next_st.state = S_READ;
        end
      end
      S_READ: begin
        if (memAck) begin
          // align read lanes to the destination lanes
          next_st.data = (memRdata >> {st.src[1:0], 3'h0}) << {st.dst[1:0], 3'h0};
          next_st.mAddr = st.dst;
          next_st.mSel = laneSel(st.size, st.dst[1:0]);
          next_st.state = S_WRITE;
        end
      end
      S_WRITE: begin
        if (memAck) begin
          next_st.src = srcStep;
          next_st.dst = dstStep;
          next_st.cnt = cntLeft;
          next_st.blkLeft = blkAfter;
          next_st.state = S_READ;
          next_st.mAddr = srcStep;
          next_st.mSel = laneSel(st.size, srcStep[1:0]);
          if (ringHit) begin
            next_st.src = st.rStart;
            next_st.mAddr = st.rStart;
            next_st.mSel = laneSel(st.size, st.rStart[1:0]);
            evtSet[IRQ_REPEAT_AREA_END_IRQ] = 1'b1;
            if (st.eStop) begin
              next_st.en = 1'b0;
              next_st.state = S_IDLE;
            end
          end
          if (cntLeft == RST_WORD) begin
            evtSet[IRQ_TRANSFER_END_IRQ] = 1'b1;
            next_st.en = 1'b0;
            next_st.blkLeft = RST_WORD;
            next_st.state = S_IDLE;
          end else if (blkAfter == RST_WORD) begin
            // block boundary, next block from idle
            next_st.state = S_IDLE;
          end
        end
      end
    endcase
    // register writes, software wins over the sequencer except on status, where a new event wins
    if (busHit && we_i) begin
      unique case (adr_i)
        OFS_SRC: next_st.src = (st.src & ~wmask) | (dat_i & wmask);
        OFS_DST: next_st.dst = (st.dst & ~wmask) | (dat_i & wmask);
        OFS_OFFSET: next_st.ofs = (st.ofs & ~wmask) | (dat_i & wmask);
        OFS_COUNT: next_st.cnt = (st.cnt & ~wmask) | (dat_i & wmask);
        OFS_BSIZE: next_st.bsz = (st.bsz & ~wmask) | (dat_i & wmask);
        OFS_RSTART: next_st.rStart = (st.rStart & ~wmask) | (dat_i & wmask);
        OFS_RSIZE: next_st.rSize = (st.rSize & ~wmask) | (dat_i & wmask);
        OFS_MODE: begin
          if (sel_i[0]) begin
            next_st.en = dat_i[MODE_EN];
            next_st.xfer = xfer_e'(dat_i[MODE_XFER +: 2]);
            next_st.size = size_e'(dat_i[MODE_SIZE +: 2]);
            next_st.eStop = dat_i[MODE_ESTOP];
            // disabling drops the partly done block
            if (!dat_i[MODE_EN]) begin
              next_st.blkLeft = RST_WORD;
            end
          end
        end
        OFS_ADDRCTL: begin
          if (sel_i[0]) begin
            next_st.srcMode = addr_mode_e'(dat_i[ACTL_SRC +: 2]);
            next_st.dstMode = addr_mode_e'(dat_i[ACTL_DST +: 2]);
            next_st.ringEn = dat_i[ACTL_RING];
          end
        end
        OFS_STATUS: begin
          // write one to clear, a new event wins
          if (sel_i[0]) begin
            next_st.sts = st.sts & ~dat_i[1:0];
          end
        end
        OFS_MASK: begin
          if (sel_i[0]) begin
            next_st.msk = dat_i[1:0];
          end
        end
        default: begin
        end
      endcase
    end
    // an event in the same cycle as a clear keeps its bit
    next_st.sts = next_st.sts | evtSet;
  end

  ////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.state <= S_IDLE;
      st.sts <= RST_IRQ;
      st.msk <= RST_IRQ;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs
  assign dat_o = st.rdat;
  assign ack_o = st.ack;
  assign memReq = (st.state != S_IDLE);
  assign memWe = (st.state == S_WRITE);
  assign memAddr = st.mAddr;
  assign memSel = st.mSel;
  assign memWdata = st.data;
  assign irq = |(st.sts & st.msk);

  ////////////////////////////////////////////////////////////////
  // assertions
  a_src_increment: assert property (@(posedge mclk) disable iff (!resetn)
    xferDone && !ringHit && st.srcMode == AM_INC && !(busHit && we_i)
    |=> st.src == $past(st.src) + $past(unitBytes))
    else $error("source address did not step by the unit");
  a_dst_increment: assert property (@(posedge mclk) disable iff (!resetn)
    xferDone && st.dstMode == AM_INC && !(busHit && we_i)
    |=> st.dst == $past(st.dst) + $past(unitBytes))
    else $error("destination address did not step by the unit");
  a_offset_add: assert property (@(posedge mclk) disable iff (!resetn)
    xferDone && !ringHit && st.srcMode == AM_OFFSET && !(busHit && we_i)
    |=> st.src == $past(st.src) + $past(st.ofs))
    else $error("offset was not added to the source");
  a_count_unit: assert property (@(posedge mclk) disable iff (!resetn)
    xferDone && !(busHit && we_i) |=> st.cnt == $past(st.cnt) - $past(unitBytes))
    else $error("count did not fall by the access size");
  a_count_long: assert property (@(posedge mclk) disable iff (!resetn)
    xferDone && st.size == SZ_LONG && !(busHit && we_i)
    |=> st.cnt == $past(st.cnt) - 32'h00000004)
    else $error("longword transfer did not subtract four");
  a_normal_block: assert property (@(posedge mclk) disable iff (!resetn)
    st.state == S_IDLE && st.en && st.cnt != RST_WORD && st.blkLeft == RST_WORD
    && st.xfer == XF_NORMAL && !(busHit && we_i)
    |=> st.state == S_READ && st.blkLeft == $past(st.cnt))
    else $error("normal mode used the block size");
  a_block_bound: assert property (@(posedge mclk) disable iff (!resetn)
    st.state == S_READ |-> st.blkLeft <= st.cnt && st.blkLeft != RST_WORD)
    else $error("block length exceeds remaining count");
  a_short_block: assert property (@(posedge mclk) disable iff (!resetn)
    st.state == S_IDLE && st.en && st.blkLeft == RST_WORD && st.xfer == XF_BLOCK
    && st.cnt != RST_WORD && st.cnt < st.bsz && !(busHit && we_i)
    |=> st.blkLeft == $past(st.cnt))
    else $error("final short block not sized to the remainder");
  a_ring_reload: assert property (@(posedge mclk) disable iff (!resetn)
    xferDone && ringHit && !st.eStop && cntLeft != RST_WORD && blkAfter != RST_WORD
    && !(busHit && we_i)
    |=> st.src == $past(st.rStart) && st.state == S_READ && memAddr == st.src)
    else $error("ring end did not reload and continue");
  a_transfer_end_irq_event: assert property (@(posedge mclk) disable iff (!resetn)
    xferDone && cntLeft == RST_WORD && !(busHit && we_i)
    |=> st.sts[IRQ_TRANSFER_END_IRQ] && !st.en && st.state == S_IDLE)
    else $error("transfer end not flagged");
  a_repeat_area_end_irq_event: assert property (@(posedge mclk) disable iff (!resetn)
    xferDone && ringHit |=> st.sts[IRQ_REPEAT_AREA_END_IRQ])
    else $error("repeat area end not flagged");
  a_suspend_hold: assert property (@(posedge mclk) disable iff (!resetn)
    xferDone && ringHit && st.eStop && !(busHit && we_i)
    |=> (st.state == S_IDLE && !memReq) ##1 (st.state == S_IDLE || st.en))
    else $error("channel did not suspend at repeat end");
endmodule : dma_channel_ring_repeat
`default_nettype wire

// [design/dma_ring_pkg.sv]
package dma_ring_pkg;
  // register byte offsets, one word each
  localparam logic [7:0] OFS_SRC = 8'h00;
  localparam logic [7:0] OFS_DST = 8'h04;
  localparam logic [7:0] OFS_OFFSET = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;
  localparam logic [7:0] OFS_BSIZE = 8'h10;
  localparam logic [7:0] OFS_MODE = 8'h14;
  localparam logic [7:0] OFS_ADDRCTL = 8'h18;
  localparam logic [7:0] OFS_RSTART = 8'h1c;
  localparam logic [7:0] OFS_RSIZE = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_MASK = 8'h28;
  // channel_mode_control fields
  localparam int MODE_EN = 0;
  localparam int MODE_XFER = 1;
  localparam int MODE_SIZE = 3;
  localparam int MODE_ESTOP = 5;
  // channel_address_control fields
  localparam int ACTL_SRC = 0;
  localparam int ACTL_DST = 2;
  localparam int ACTL_RING = 4;
  // status and mask bits
  localparam int IRQ_TRANSFER_END_IRQ = 0;
  localparam int IRQ_REPEAT_AREA_END_IRQ = 1;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [1:0] RST_IRQ = 2'h0;
  // transfer modes
  typedef enum logic [1:0] {
    XF_NORMAL = 2'h0,
    XF_REPEAT = 2'h1,
    XF_BLOCK = 2'h2
  } xfer_e;
  // access units
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } size_e;
  // address update modes
  typedef enum logic [1:0] {
    AM_FIXED = 2'h0,
    AM_INC = 2'h1,
    AM_DEC = 2'h2,
    AM_OFFSET = 2'h3
  } addr_mode_e;
  // channel sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_READ = 3'b010,
    S_WRITE = 3'b100
  } state_e;
endpackage : dma_ring_pkg

// [design/dma_addr_step.sv]
`timescale 1ns/10ps
`default_nettype none
// next address of one side after a single data transfer
module dma_addr_step #(
  parameter int AW = 32
) (
  // current address and how it moves
  input wire logic [AW-1:0] addr,
  input wire dma_ring_pkg::addr_mode_e mode,
  input wire logic [AW-1:0] unitBytes,
  input wire logic [AW-1:0] offset,
  // stepped address
  output logic [AW-1:0] nextAddr
);
  import dma_ring_pkg::*;

  // one adder per moving mode, a pass-through for fixed, chosen by the mode field
  always_comb begin
    unique case (mode)
      AM_FIXED: nextAddr = addr;
      AM_INC: nextAddr = addr + unitBytes;
      AM_DEC: nextAddr = addr - unitBytes;
      AM_OFFSET: nextAddr = addr + offset;
    endcase
  end
endmodule : dma_addr_step
`default_nettype wire

// [sim/dma_ram_model.sv]
`timescale 1ns/10ps
`default_nettype none
// on-chip ram behind the channel, answering after a settable wait
module dma_ram_model (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // memory port
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [31:0] memAddr,
  input wire logic [3:0] memSel,
  input wire logic [31:0] memWdata,
  output logic [31:0] memRdata,
  output logic memAck,
  // wait cycles before each answer
  input wire logic [1:0] waitCycles
);
  logic [31:0] mem [0:511]; // word store, preloaded by the bench
  logic [31:0] rdReg; // last word read
  logic [1:0] waitCnt; // cycles waited so far
  // data is only good with the answer; otherwise show a changed value
  assign memRdata = memAck ? rdReg : ~rdReg;
  ////////////////////////////////////////////////////////////////////
  // one answer per access, then drop the answer for a cycle
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      memAck <= 1'b0;
      waitCnt <= 2'h0;
      rdReg <= 32'h0;
    end else if (memAck) begin
      memAck <= 1'b0;
      waitCnt <= 2'h0;
    end else if (memReq && waitCnt == waitCycles) begin
      memAck <= 1'b1;
      rdReg <= mem[memAddr[10:2]];
      // byte lanes written only where selected
      for (int b = 0; b < 4; b++) begin
        if (memWe && memSel[b]) begin
          mem[memAddr[10:2]][8*b+:8] <= memWdata[8*b+:8];
        end
      end
    end else if (memReq) begin
      waitCnt <= waitCnt + 2'h1;
    end
  end
endmodule : dma_ram_model
`default_nettype wire

// [sim/dma_channel_ring_repeat_test.sv]
`timescale 1ns/10ps
`default_nettype none
module dma_channel_ring_repeat_test;
  import dma_ring_pkg::*;
  logic mclk, resetn, cyc, stb, we, ack, memReq, memWe, memAck, irq; // bench wires
  logic [7:0] adr; // register address
  logic [3:0] sel, memSel; // byte enables
  logic [31:0] wdat, rdat, memAddr, memWdata, memRdata, q; // data paths
  logic [1:0] waitCycles; // ram wait setting
  int failCount, numChecks, cycles, writes; // counters
  dma_channel_ring_repeat i_dma_channel_ring_repeat (.mclk(mclk), .resetn(resetn),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
    .dat_o(rdat), .ack_o(ack), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memSel(memSel), .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck), .irq(irq));
  dma_ram_model i_dma_ram_model (.mclk(mclk), .resetn(resetn), .memReq(memReq),
    .memWe(memWe), .memAddr(memAddr), .memSel(memSel), .memWdata(memWdata),
    .memRdata(memRdata), .memAck(memAck), .waitCycles(waitCycles));
  ////////////////////////////////////////////////////////////////////
  // clock and run limit
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (memAck && memWe) writes <= writes + 1;
    if (cycles == 20000) begin
      failCount++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // one classic single cycle, held until the answer
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    // the answer of the last access stood one cycle only
    check("answer dropped", 32'h0, {31'h0, ack});
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // wait for the answer; only the run limit ends a hang
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    wb(1'b0, a, 32'h0);
    check(what, exp, q);
  endtask : rdchk
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    check("irq raised", 32'h1, {31'h0, irq});
  endtask : wait_irq
  ////////////////////////////////////////////////////////////////////
  // reset values, read back, unmapped place
  task automatic test_regs;
    for (int i = 0; i < 11; i++) rdchk(8'(4 * i), RST_WORD, "reset value");
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 8'(4 * i), 32'h5a5a0000 | i);
      rdchk(8'(4 * i), 32'h5a5a0000 | i, "read back");
    end
    wb(1'b1, 8'h3c, 32'hffffffff);
    rdchk(8'h3c, 32'h0, "unmapped read");
  endtask : test_regs
  // normal mode run with one address mode per side and one access size
  task automatic run_step(input logic [31:0] actl, mode, cnt, eSrc, eDst, input logic m,
    input logic [1:0] w);
    int n;
    @(posedge mclk);
    waitCycles <= w;
    wb(1'b1, OFS_SRC, 32'h40);
    wb(1'b1, OFS_DST, 32'h200);
    wb(1'b1, OFS_OFFSET, 32'h10);
    wb(1'b1, OFS_COUNT, cnt);
    wb(1'b1, OFS_BSIZE, 32'h4);
    wb(1'b1, OFS_ADDRCTL, actl);
    wb(1'b1, OFS_MASK, {31'h0, m});
    wb(1'b1, OFS_MODE, mode);
    n = 0;
    do begin
      wb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (q[IRQ_TRANSFER_END_IRQ] !== 1'b1 && n < 100);
    check("end flag", 32'h1, {31'h0, q[IRQ_TRANSFER_END_IRQ]});
    check("end irq masking", {31'h0, m}, {31'h0, irq});
    rdchk(OFS_SRC, eSrc, "source step");
    rdchk(OFS_DST, eDst, "destination step");
    rdchk(OFS_COUNT, 32'h0, "count drained");
    wb(1'b1, OFS_STATUS, 32'h3);
    check("irq cleared", 32'h0, {31'h0, irq});
  endtask : run_step
  // ring source, block mode, suspend on ring end
  task automatic test_ring;
    @(posedge mclk);
    waitCycles <= 2'h1;
    wb(1'b1, OFS_SRC, 32'h0);
    wb(1'b1, OFS_DST, 32'h200);
    wb(1'b1, OFS_COUNT, 32'h200);
    wb(1'b1, OFS_BSIZE, 32'hc0);
    wb(1'b1, OFS_RSTART, 32'h0);
    wb(1'b1, OFS_RSIZE, 32'h100);
    wb(1'b1, OFS_ADDRCTL, 32'h15);
    wb(1'b1, OFS_MASK, 32'h3);
    writes = 0;
    wb(1'b1, OFS_MODE, 32'h35);
    wait_irq();
    rdchk(OFS_STATUS, 32'h2, "ring end status");
    rdchk(OFS_SRC, 32'h0, "ring reload");
    rdchk(OFS_COUNT, 32'h100, "count at ring end");
    rdchk(OFS_DST, 32'h300, "destination at ring end");
    repeat (8) @(posedge mclk);
    check("suspended", 32'h0, {31'h0, memReq});
    rdchk(OFS_COUNT, 32'h100, "count held");
    wb(1'b1, OFS_STATUS, 32'h2);
    check("ring irq cleared", 32'h0, {31'h0, irq});
    // software resumes the suspended block
    wb(1'b1, OFS_MODE, 32'h35);
    wait_irq();
    rdchk(OFS_STATUS, 32'h3, "final status");
    rdchk(OFS_COUNT, 32'h0, "count done");
    rdchk(OFS_DST, 32'h400, "destination done");
    check("write count", 32'd128, writes);
    // software stops the channel and clears the flags
    wb(1'b1, OFS_MODE, 32'h0);
    wb(1'b1, OFS_STATUS, 32'h3);
    check("irq after stop", 32'h0, {31'h0, irq});
    for (int k = 0; k < 128; k++) begin
      check("moved data", 32'h5a000000 | (k % 64), i_dma_ram_model.mem[128 + k]);
    end
    check("past the end", 32'h5a000100, i_dma_ram_model.mem[256]);
  endtask : test_ring
  // ring wrap inside one block, no suspend, whole count as one block
  task automatic test_wrap;
    wb(1'b1, OFS_SRC, 32'hf8);
    wb(1'b1, OFS_DST, 32'h200);
    wb(1'b1, OFS_COUNT, 32'h10);
    wb(1'b1, OFS_BSIZE, 32'h0);
    wb(1'b1, OFS_RSTART, 32'h0);
    wb(1'b1, OFS_RSIZE, 32'h100);
    wb(1'b1, OFS_ADDRCTL, 32'h15);
    wb(1'b1, OFS_MODE, 32'h15);
    repeat (80) @(posedge mclk);
    rdchk(OFS_STATUS, 32'h3, "wrap status");
    rdchk(OFS_SRC, 32'h8, "wrap source");
    rdchk(OFS_DST, 32'h210, "wrap destination");
    check("wrap before end", 32'h5a00003f, i_dma_ram_model.mem[129]);
    check("wrap after start", 32'h5a000000, i_dma_ram_model.mem[130]);
    wb(1'b1, OFS_STATUS, 32'h3);
  endtask : test_wrap
  ////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  // main sequence
  initial begin
    {cyc, stb, we, adr, wdat, waitCycles, resetn} = '0;
    sel = 4'hf;
    {failCount, numChecks, cycles, writes} = '0;
    for (int k = 0; k < 512; k++) i_dma_ram_model.mem[k] = 32'h5a000000 | k;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    test_regs();
    run_step(32'h07, 32'h09, 32'h6, 32'h70, 32'h206, 1'b1, 2'h1);
    run_step(32'h02, 32'h01, 32'h2, 32'h3e, 32'h200, 1'b0, 2'h0);
    check("byte and word lanes", 32'h0014005a, i_dma_ram_model.mem[128]);
    run_step(32'h0c, 32'h11, 32'h8, 32'h40, 32'h220, 1'b1, 2'h2);
    test_wrap();
    test_ring();
    close_out();
  end
endmodule : dma_channel_ring_repeat_test
`default_nettype wire
